/* logic/malt_top.sv */
`timescale 1ns/10ps
`include "malt_cfg.svh"
module malt_top #(
  parameter int PORTS = 7
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic [15:0]        reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [31:0]        reg_wdata,
  output logic      [31:0]        reg_rdata,
  output logic                    reg_rvalid,
  input  wire logic               hash_fid_en,
  input  wire logic               lrn_req,
  input  wire logic [47:0]        lrn_mac,
  input  wire logic [6:0]         lrn_fid,
  input  wire logic [2:0]         lrn_port,
  input  wire logic [2:0]         lrn_inst,
  output logic                    lrn_ack,
  input  wire logic               da_req,
  input  wire logic [47:0]        da_mac,
  input  wire logic [6:0]         da_fid,
  output logic                    da_ack,
  output logic                    da_hit,
  output logic                    da_static,
  output logic      [6:0]         da_fwd,
  input  wire logic               age_tick,
  output logic      [PORTS*8-1:0] port_tx_en,
  output logic      [PORTS*8-1:0] port_rx_en,
  output logic      [PORTS*8-1:0] port_learn_dis
);
  if (PORTS < 1 || PORTS > 7) begin : g_chk
    $error("malt_top: PORTS must be 1 to 7");
  end

  malt_pkg::malt_bkt_t mem [`MALT_NBKT];
  malt_pkg::malt_lru_t lru [`MALT_NBKT];

  malt_pkg::malt_st_t  st_ff;
  malt_pkg::malt_op_t  op_ff;
  malt_pkg::malt_ent_t ent_ff;
  logic [9:0]          bkt_ff;
  logic [11:0]         scan_ff;
  logic                direct_ff;
  logic                go_ff;
  logic                found_ff;
  logic                age_pend_ff;
  logic [12:0]         cnt_ff;
  logic [47:0]         imac_ff;
  logic [6:0]          ifid_ff;
  logic [11:0]         eidx0_ff;
  logic [9:0]          eidx1_ff;
  logic [2:0]          ev_ff;

  malt_ps_if ps ();

  malt_port_state #(
    .PORTS (PORTS)
  ) u_ps (
    .clock   (clock),
    .srst    (srst),
    .ps      (ps),
    .tx_en   (port_tx_en),
    .rx_en   (port_rx_en),
    .lrn_off (port_learn_dis)
  );

  logic ps_hit;
  logic wr_ctl;
  logic abort;
  logic ent4_rd;
  assign ps_hit  = (reg_addr[11:8] == `MALT_PG_PORT) && (reg_addr[15:12] != 4'h0)
                   && (32'(reg_addr[15:12]) <= PORTS);
  assign ps.port   = reg_addr[14:12] - 3'h1;
  assign ps.ptr_we = reg_wr && ps_hit && (reg_addr[7:0] == `MALT_A_PTR);
  assign ps.st_we  = reg_wr && ps_hit && (reg_addr[7:0] == `MALT_A_PST);
  assign ps.wdata  = reg_wdata[7:0];
  assign ps.lrn_port = lrn_port;
  assign ps.lrn_inst = lrn_inst;
  assign wr_ctl  = reg_wr && (reg_addr == `MALT_A_CTL);
  assign abort   = wr_ctl && !reg_wdata[`MALT_F_GO];
  assign ent4_rd = reg_rd && (reg_addr == `MALT_A_ENT4);

  // one hash circuit serves host and datapath, so the host sees forwarding buckets
  logic        pick_lrn;
  logic        pick_da;
  logic [9:0]  hbkt;
  assign pick_lrn = lrn_req && !lrn_ack;
  assign pick_da  = da_req && !da_ack;

  malt_hash #(
    .BW (10)
  ) u_hash (
    .mac     (go_ff ? imac_ff : pick_lrn ? lrn_mac : da_mac),
    .filter_group_id     (go_ff ? ifid_ff : pick_lrn ? lrn_fid : da_fid),
    .use_fid (hash_fid_en),
    .bucket  (hbkt)
  );

  logic                in_scan;
  logic [9:0]          rd_bkt;
  malt_pkg::malt_bkt_t cur;
  malt_pkg::malt_lru_t rnk;
  logic [47:0]         kmac;
  logic [6:0]          kfid;
  assign in_scan = (st_ff == malt_pkg::S_SCAN) || (st_ff == malt_pkg::S_HOLD);
  assign rd_bkt  = in_scan ? scan_ff[11:2] : bkt_ff;
  assign cur     = mem[rd_bkt];
  assign rnk     = lru[rd_bkt];
  assign kmac = (st_ff == malt_pkg::S_LRN) ? lrn_mac : (st_ff == malt_pkg::S_DA) ? da_mac : imac_ff;
  assign kfid = (st_ff == malt_pkg::S_LRN) ? lrn_fid : (st_ff == malt_pkg::S_DA) ? da_fid : ifid_ff;

  logic       mhit;
  logic       mstat;
  logic [1:0] mway;
  logic       ffree;
  logic [1:0] fway;
  logic [1:0] vway;
  logic [2:0] nstat;
  always_comb begin
    logic [1:0] vr;
    logic       v;
    vr = 2'h0;
    v = 1'b0;
    mhit = 1'b0;
    mstat = 1'b0;
    mway = 2'h0;
    ffree = 1'b0;
    fway = 2'h0;
    vway = 2'h0;
    nstat = 3'h0;
    for (int w = 0; w < 4; w++) begin
      v = malt_pkg::ent_valid(cur[w]);
      nstat = nstat + {2'h0, cur[w].stat};
      if (v && cur[w].mac == kmac && (!hash_fid_en || cur[w].filter_group_id == kfid)
          && (!mhit || (cur[w].stat && !mstat))) begin
        mhit = 1'b1;
        mstat = cur[w].stat;
        mway = 2'(w);
      end
      if (!v && !ffree) begin
        ffree = 1'b1;
        fway = 2'(w);
      end
      if (v && !cur[w].stat && rnk[w] >= vr) begin
        vr = rnk[w];
        vway = 2'(w);
      end
    end
  end

  logic                pfull;
  logic [1:0]          pway;
  logic [1:0]          wway;
  logic                hhit;
  logic                wfail;
  logic                afull;
  logic                lfail;
  logic                sv;
  logic                scan_end;
  logic                host_wr;
  logic                do_lrn;
  malt_pkg::malt_ent_t wr_ent;
  malt_pkg::malt_ent_t lrn_ent;
  assign pfull = (nstat == 3'h4);
  assign pway  = mhit ? mway : ffree ? fway : vway;
  assign wway  = direct_ff ? imac_ff[1:0] : pway;
  assign hhit  = direct_ff ? malt_pkg::ent_valid(cur[imac_ff[1:0]]) : mhit;
  assign wfail = !direct_ff && !mhit && pfull;
  assign afull = !direct_ff && !(mhit && mstat) && (nstat == 3'h2 || nstat == 3'h3);
  assign lfail = !mhit && pfull;
  assign host_wr = (st_ff == malt_pkg::S_HOST) && (op_ff == malt_pkg::OP_WR);
  assign do_lrn  = (st_ff == malt_pkg::S_LRN) && !ps.lrn_dis && (32'(lrn_port) < PORTS);
  assign sv = malt_pkg::ent_valid(cur[scan_ff[1:0]]);
  assign scan_end = scan_ff == `MALT_LAST_ENT && !abort
                    && ((st_ff == malt_pkg::S_SCAN && !sv) || (st_ff == malt_pkg::S_HOLD && ent4_rd));
  always_comb begin
    wr_ent = ent_ff;
    wr_ent.stat = 1'b1;
    lrn_ent = '0;
    lrn_ent.age = `MALT_AGE_DFLT;
    lrn_ent.inst = lrn_inst;
    lrn_ent.fwd = 7'h01 << lrn_port;
    lrn_ent.filter_group_id = lrn_fid;
    lrn_ent.mac = lrn_mac;
  end

  always_ff @(posedge clock) begin
    if (st_ff == malt_pkg::S_CLR) begin
      mem[bkt_ff] <= '0;
      lru[bkt_ff] <= `MALT_LRU_RST;
    end else if (host_wr && !wfail) begin
      mem[bkt_ff][wway] <= wr_ent;
      lru[bkt_ff] <= malt_pkg::lru_touch(rnk, wway);
    end else if (do_lrn && !lfail) begin
      // a static hit is only touched, learning never rewrites it
      if (!mstat) mem[bkt_ff][pway] <= lrn_ent;
      lru[bkt_ff] <= malt_pkg::lru_touch(rnk, pway);
    end else if (st_ff == malt_pkg::S_DA && mhit) begin
      if (!mstat) mem[bkt_ff][mway].age <= `MALT_AGE_DFLT;
      lru[bkt_ff] <= malt_pkg::lru_touch(rnk, mway);
    end else if (st_ff == malt_pkg::S_AGE) begin
      mem[bkt_ff] <= malt_pkg::bkt_aged(cur);
    end
  end

  // the table is cleared one bucket per cycle after reset; host ops wait for it
  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff   <= malt_pkg::S_CLR;
      bkt_ff  <= 10'h000;
      scan_ff <= 12'h000;
    end else begin
      unique case (st_ff)
        malt_pkg::S_CLR, malt_pkg::S_AGE: begin
          bkt_ff <= bkt_ff + 10'h001;
          if (bkt_ff == `MALT_LAST_BKT) st_ff <= malt_pkg::S_IDLE;
        end
        malt_pkg::S_IDLE: begin
          if (go_ff) begin
            if (op_ff == malt_pkg::OP_SRCH) begin
              st_ff <= malt_pkg::S_SCAN;
              scan_ff <= 12'h000;
            end else begin
              st_ff <= malt_pkg::S_HOST;
              bkt_ff <= direct_ff ? imac_ff[11:2] : hbkt;
            end
          end else if (pick_lrn) begin
            st_ff <= malt_pkg::S_LRN;
            bkt_ff <= hbkt;
          end else if (pick_da) begin
            st_ff <= malt_pkg::S_DA;
            bkt_ff <= hbkt;
          end else if (age_pend_ff) begin
            st_ff <= malt_pkg::S_AGE;
            bkt_ff <= 10'h000;
          end
        end
        malt_pkg::S_HOST, malt_pkg::S_LRN, malt_pkg::S_DA: begin
          st_ff <= malt_pkg::S_IDLE;
        end
        malt_pkg::S_SCAN: begin
          if (abort || scan_end) st_ff <= malt_pkg::S_IDLE;
          else if (sv) st_ff <= malt_pkg::S_HOLD;
          else scan_ff <= scan_ff + 12'h001;
        end
        malt_pkg::S_HOLD: begin
          if (abort || scan_end) begin
            st_ff <= malt_pkg::S_IDLE;
          end else if (ent4_rd) begin
            st_ff <= malt_pkg::S_SCAN;
            scan_ff <= scan_ff + 12'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      age_pend_ff <= 1'b0;
    end else if (age_tick) begin
      age_pend_ff <= 1'b1;
    end else if (st_ff == malt_pkg::S_IDLE && !go_ff && !pick_lrn && !pick_da) begin
      age_pend_ff <= 1'b0;
    end
  end

  // a host write of go wins over completion, so a relaunch is never lost
  always_ff @(posedge clock) begin
    if (srst) begin
      go_ff <= 1'b0;
      op_ff <= malt_pkg::OP_NONE;
      direct_ff <= 1'b0;
    end else if (wr_ctl) begin
      go_ff <= reg_wdata[`MALT_F_GO];
      op_ff <= malt_pkg::malt_op_t'(reg_wdata[1:0]);
      direct_ff <= reg_wdata[`MALT_F_DIRECT];
    end else if (st_ff == malt_pkg::S_HOST || scan_end) begin
      go_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      found_ff <= 1'b0;
      cnt_ff <= 13'h0000;
    end else if (st_ff == malt_pkg::S_IDLE && go_ff && op_ff == malt_pkg::OP_SRCH) begin
      found_ff <= 1'b0;
      cnt_ff <= 13'h0000;
    end else if (st_ff == malt_pkg::S_HOST) begin
      found_ff <= (op_ff == malt_pkg::OP_WR) ? !wfail : hhit;
    end else if (st_ff == malt_pkg::S_SCAN && sv && !abort) begin
      found_ff <= 1'b1;
      cnt_ff <= cnt_ff + 13'h0001;
    end else if (st_ff == malt_pkg::S_HOLD && ent4_rd) begin
      found_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ent_ff <= '0;
    end else if (st_ff == malt_pkg::S_HOST && op_ff != malt_pkg::OP_WR) begin
      ent_ff <= hhit ? cur[direct_ff ? imac_ff[1:0] : mway] : '0;
    end else if (st_ff == malt_pkg::S_SCAN && sv && !abort) begin
      ent_ff <= cur[scan_ff[1:0]];
    end else if (scan_end) begin
      ent_ff <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `MALT_A_ENT1: {ent_ff.stat, ent_ff.src_filt, ent_ff.dst_filt, ent_ff.age}
                      <= reg_wdata[31:26];
        `MALT_A_ENT2: {ent_ff.ovr, ent_ff.fwd} <= {reg_wdata[31], reg_wdata[6:0]};
        `MALT_A_ENT3: {ent_ff.filter_group_id, ent_ff.mac[47:32]} <= reg_wdata[22:0];
        `MALT_A_ENT4: ent_ff.mac[31:0] <= reg_wdata;
        default: ;
      endcase
      if (reg_addr == `MALT_A_ENT1) ent_ff.inst <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      imac_ff <= 48'h0;
      ifid_ff <= 7'h00;
    end else if (reg_wr && reg_addr == `MALT_A_IDX0) begin
      {ifid_ff, imac_ff[47:32]} <= reg_wdata[22:0];
    end else if (reg_wr && reg_addr == `MALT_A_IDX1) begin
      imac_ff[31:0] <= reg_wdata;
    end
  end

  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  assign ev_set[`MALT_EV_AFULL] = host_wr && !wfail && afull;
  assign ev_set[`MALT_EV_WFAIL] = host_wr && wfail;
  assign ev_set[`MALT_EV_LFAIL] = do_lrn && lfail;
  assign ev_clr = (reg_wr && reg_addr == `MALT_A_EVT) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge clock) begin
    if (srst) begin
      ev_ff <= 3'h0;
      eidx0_ff <= 12'h000;
      eidx1_ff <= 10'h000;
    end else begin
      ev_ff <= (ev_ff & ~ev_clr) | ev_set;
      if (ev_set[`MALT_EV_AFULL]) eidx0_ff <= {bkt_ff, wway};
      if (ev_set[`MALT_EV_WFAIL]) eidx0_ff <= {2'h0, bkt_ff};
      if (ev_set[`MALT_EV_LFAIL]) eidx1_ff <= bkt_ff;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (ps_hit && reg_addr[7:0] == `MALT_A_PTR) begin
      rd_mux[7:0] = ps.ptr_rd;
    end else if (ps_hit && reg_addr[7:0] == `MALT_A_PST) begin
      rd_mux[2:0] = ps.st_rd;
    end else begin
      unique case (reg_addr)
        `MALT_A_IDX0: rd_mux[22:0] = {ifid_ff, imac_ff[47:32]};
        `MALT_A_IDX1: rd_mux = imac_ff[31:0];
        `MALT_A_CTL: begin
          rd_mux[1:0] = op_ff;
          rd_mux[`MALT_F_DIRECT] = direct_ff;
          rd_mux[`MALT_F_VOE] = found_ff || !go_ff;
          rd_mux[`MALT_F_FOUND] = found_ff;
          rd_mux[`MALT_F_GO] = go_ff;
          rd_mux[`MALT_F_CNT +: 13] = cnt_ff;
        end
        `MALT_A_EIDX0: rd_mux[11:0] = eidx0_ff;
        `MALT_A_EIDX1: rd_mux[9:0] = eidx1_ff;
        `MALT_A_EVT: rd_mux[2:0] = ev_ff;
        `MALT_A_ENT1: rd_mux = {ent_ff.stat, ent_ff.src_filt, ent_ff.dst_filt, ent_ff.age,
                                23'h0, ent_ff.inst};
        `MALT_A_ENT2: rd_mux = {ent_ff.ovr, 24'h0, ent_ff.fwd};
        `MALT_A_ENT3: rd_mux = {9'h0, ent_ff.filter_group_id, ent_ff.mac[47:32]};
        `MALT_A_ENT4: rd_mux = ent_ff.mac[31:0];
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lrn_ack <= 1'b0;
      da_ack <= 1'b0;
      da_hit <= 1'b0;
      da_static <= 1'b0;
      da_fwd <= 7'h00;
    end else begin
      lrn_ack <= (st_ff == malt_pkg::S_LRN);
      da_ack <= (st_ff == malt_pkg::S_DA);
      if (st_ff == malt_pkg::S_DA) begin
        da_hit <= mhit;
        da_static <= mhit && mstat;
        da_fwd <= mhit ? cur[mway].fwd : 7'h00;
      end
    end
  end
endmodule

/* logic/malt_cfg.svh */
`ifndef MALT_CFG_SVH
`define MALT_CFG_SVH
`define MALT_NBKT      1024
`define MALT_LAST_BKT  10'h3ff
`define MALT_LAST_ENT  12'hfff
`define MALT_A_IDX0    16'h0400
`define MALT_A_IDX1    16'h0404
`define MALT_A_CTL     16'h0408
`define MALT_A_EIDX0   16'h0410
`define MALT_A_EIDX1   16'h0414
`define MALT_A_EVT     16'h0418
`define MALT_A_ENT1    16'h0420
`define MALT_A_ENT2    16'h0424
`define MALT_A_ENT3    16'h0428
`define MALT_A_ENT4    16'h042c
`define MALT_PG_PORT   4'hb
`define MALT_A_PTR     8'h01
`define MALT_A_PST     8'h04
`define MALT_F_DIRECT  2
`define MALT_F_VOE     5
`define MALT_F_FOUND   6
`define MALT_F_GO      7
`define MALT_F_CNT     16
`define MALT_EV_AFULL  0
`define MALT_EV_WFAIL  1
`define MALT_EV_LFAIL  2
`define MALT_PTR_RST   8'h00
`define MALT_PST_RST   3'h6
`define MALT_AGE_DFLT  3'h3
`define MALT_LRU_RST   8'he4
`endif

/* logic/malt_pkg.sv */
package malt_pkg;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_WR   = 2'h1,
    OP_RD   = 2'h2,
    OP_SRCH = 2'h3
  } malt_op_t;
  typedef enum logic [2:0] {S_CLR, S_IDLE, S_HOST, S_LRN, S_DA, S_SCAN, S_HOLD, S_AGE} malt_st_t;
  typedef struct packed {
    logic        stat;
    logic        src_filt;
    logic        dst_filt;
    logic [2:0]  age;
    logic [2:0]  inst;
    logic        ovr;
    logic [6:0]  fwd;
    logic [6:0]  filter_group_id;
    logic [47:0] mac;
  } malt_ent_t;
  typedef malt_ent_t [3:0] malt_bkt_t;
  typedef logic [3:0][1:0] malt_lru_t;

  function automatic logic ent_valid(malt_ent_t e);
    return e.stat || (e.age != 3'h0);
  endfunction

  // rank 0 is most recent, 3 is the replacement candidate
  function automatic malt_lru_t lru_touch(malt_lru_t r, logic [1:0] w);
    malt_lru_t n;
    n = r;
    for (int i = 0; i < 4; i++) begin
      if (r[i] < r[w]) n[i] = r[i] + 2'h1;
    end
    n[w] = 2'h0;
    return n;
  endfunction

  function automatic malt_bkt_t bkt_aged(malt_bkt_t b);
    malt_bkt_t n;
    n = b;
    for (int i = 0; i < 4; i++) begin
      if (!b[i].stat && b[i].age != 3'h0) n[i].age = b[i].age - 3'h1;
    end
    return n;
  endfunction
endpackage

/* logic/malt_ps_if.sv */
`timescale 1ns/10ps
interface malt_ps_if;
  logic [2:0] port;
  logic       ptr_we;
  logic       st_we;
  logic [7:0] wdata;
  logic [7:0] ptr_rd;
  logic [2:0] st_rd;
  logic [2:0] lrn_port;
  logic [2:0] lrn_inst;
  logic       lrn_dis;
  modport ctl (output port, ptr_we, st_we, wdata, lrn_port, lrn_inst,
               input ptr_rd, st_rd, lrn_dis);
  modport store (input port, ptr_we, st_we, wdata, lrn_port, lrn_inst,
                 output ptr_rd, st_rd, lrn_dis);
endinterface

/* logic/malt_hash.sv */
`timescale 1ns/10ps
module malt_hash #(
  parameter int BW = 10
) (
  input  wire logic [47:0]   mac,
  input  wire logic [6:0]    filter_group_id,
  input  wire logic          use_fid,
  output logic      [BW-1:0] bucket
);
  localparam int CH = (48 + BW - 1) / BW;
  if (BW < 7 || BW > 16) begin : g_chk
    $error("malt_hash: bucket width must be 7 to 16");
  end
  // xor fold keeps every mac bit in the index at one gate level per chunk
  always_comb begin
    logic [CH*BW-1:0] pad;
    pad = {{(CH*BW-48){1'b0}}, mac};
    bucket = '0;
    for (int i = 0; i < CH; i++) begin
      bucket = bucket ^ pad[i*BW +: BW];
    end
    if (use_fid) bucket = bucket ^ {{(BW-7){1'b0}}, filter_group_id};
  end
endmodule

/* logic/malt_port_state.sv */
`timescale 1ns/10ps
`include "malt_cfg.svh"
module malt_port_state #(
  parameter int PORTS = 7
) (
  input  wire logic               clock,
  input  wire logic               srst,
  malt_ps_if.store                ps,
  output logic      [PORTS*8-1:0] tx_en,
  output logic      [PORTS*8-1:0] rx_en,
  output logic      [PORTS*8-1:0] lrn_off
);
  logic [PORTS-1:0][7:0] ptr_ff;
  logic [5:0]            sel;
  localparam logic [2:0] RST = `MALT_PST_RST;

  assign sel = {ps.port, ptr_ff[ps.port][2:0]};
  assign ps.ptr_rd = ptr_ff[ps.port];
  assign ps.st_rd = {tx_en[sel], rx_en[sel], lrn_off[sel]};
  // out-of-range port numbers never disable learning
  assign ps.lrn_dis = (32'(ps.lrn_port) < PORTS) && lrn_off[{ps.lrn_port, ps.lrn_inst}];

  always_ff @(posedge clock) begin
    if (srst) begin
      ptr_ff <= {PORTS{`MALT_PTR_RST}};
    end else if (ps.ptr_we) begin
      ptr_ff[ps.port] <= ps.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_en   <= {(PORTS*8){RST[2]}};
      rx_en   <= {(PORTS*8){RST[1]}};
      lrn_off <= {(PORTS*8){RST[0]}};
    end else if (ps.st_we) begin
      tx_en[sel]   <= ps.wdata[2];
      rx_en[sel]   <= ps.wdata[1];
      lrn_off[sel] <= ps.wdata[0];
    end
  end
endmodule

/* verif/malt_checker.sv */
`timescale 1ns/10ps
module malt_checker #(
  parameter int PORTS = 7
) (
  input wire logic               clock,
  input wire logic               srst,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic               reg_rvalid,
  input wire logic               lrn_req,
  input wire logic               lrn_ack,
  input wire logic               da_ack,
  input wire logic               da_hit,
  input wire logic               da_static,
  input wire logic [PORTS*8-1:0] port_tx_en,
  input wire logic [PORTS*8-1:0] port_rx_en,
  input wire logic [PORTS*8-1:0] port_learn_dis
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  a_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without strobe");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_state_reset: assert property ($fell(srst) |->
    (&port_tx_en) && (&port_rx_en) && !(|port_learn_dis))
    else $error("port state not at reset value");
  a_state_hold: assert property (!reg_wr |=>
    $stable({port_tx_en, port_rx_en, port_learn_dis}))
    else $error("port state moved without write");
  a_learn_latency: assert property ($rose(lrn_req) |-> !lrn_ack [*2])
    else $error("learn answered too early");
  a_learn_pulse: assert property (lrn_ack |-> lrn_req ##1 !lrn_ack)
    else $error("learn answer malformed");
  a_da_pulse: assert property (da_ack |=> !da_ack)
    else $error("lookup answer longer than one cycle");
  a_da_hold: assert property (!da_ack |-> $stable({da_hit, da_static}))
    else $error("lookup result moved without answer");
  a_da_static_hit: assert property (da_ack && da_static |-> da_hit)
    else $error("static result without hit");
  c_learn: cover property (lrn_ack);
  c_static_hit: cover property (da_ack && da_static);
  c_found_read: cover property (reg_rvalid && reg_rdata[6]);
endmodule
bind malt_top malt_checker #(.PORTS(PORTS)) u_chk (
  .clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lrn_req(lrn_req),
  .lrn_ack(lrn_ack), .da_ack(da_ack), .da_hit(da_hit), .da_static(da_static),
  .port_tx_en(port_tx_en), .port_rx_en(port_rx_en), .port_learn_dis(port_learn_dis)
);

/* verif/malt_fwd_model.sv */
`timescale 1ns/10ps
module malt_fwd_model (
  input  wire logic        clock,
  input  wire logic        lrn_ack,
  input  wire logic        da_ack,
  output logic             lrn_req,
  output logic      [47:0] lrn_mac,
  output logic      [2:0]  lrn_port,
  output logic      [2:0]  lrn_inst,
  output logic             da_req,
  output logic      [47:0] da_mac,
  output logic             hung
);
  initial {lrn_req, da_req, hung, lrn_mac, da_mac, lrn_port, lrn_inst} = '0;
  // key held until the answer edge, then request dropped on that edge
  task automatic hs(input logic is_da);
    int n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (((is_da ? da_ack : lrn_ack) !== 1'b1) && n < 3000);
    if (n >= 3000) hung <= 1'b1;
  endtask
  task automatic learn(input logic [47:0] m, input logic [2:0] p, input logic [2:0] i);
    @(posedge clock);
    lrn_req  <= 1'b1;
    lrn_mac  <= m;
    lrn_port <= p;
    lrn_inst <= i;
    hs(1'b0);
    lrn_req <= 1'b0;
    lrn_mac <= ~m; // released key must not look valid
  endtask
  task automatic lookup(input logic [47:0] m);
    @(posedge clock);
    da_req <= 1'b1;
    da_mac <= m;
    hs(1'b1);
    da_req <= 1'b0;
    da_mac <= ~m;
  endtask
endmodule

/* verif/mac_lookup_table_access_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module mac_lookup_table_access_tb;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic        age_tick = 1'b0;
  logic        hash_fid_en = 1'b0;
  logic [31:0] reg_rdata, d;
  logic        reg_rvalid, lrn_req, lrn_ack, da_req, da_ack, da_hit, da_static, hung;
  logic [47:0] lrn_mac, da_mac, m;
  logic [2:0]  lrn_port, lrn_inst;
  logic [6:0]  da_fwd;
  logic [55:0] port_tx_en, port_rx_en, port_learn_dis;
  int          num_errors = 0, samples_checked = 0, cnt;
  always #4 clock = ~clock;
  malt_top #(.PORTS(7)) DUT (.clock, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .hash_fid_en, .lrn_req, .lrn_mac, .lrn_fid(7'h0),
    .lrn_port, .lrn_inst, .lrn_ack, .da_req, .da_mac, .da_fid(7'h0), .da_ack, .da_hit,
    .da_static, .da_fwd, .age_tick, .port_tx_en, .port_rx_en, .port_learn_dis);
  malt_fwd_model u_fwd (.clock, .lrn_ack, .da_ack, .lrn_req, .lrn_mac, .lrn_port,
    .lrn_inst, .da_req, .da_mac, .hung);
  task automatic end_of_test();
    if (hung === 1'b1) num_errors++;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    `CHK("rvalid", 1'b1, reg_rvalid)
    d = reg_rdata;
  endtask
  task automatic ck(input logic [15:0] a, input logic [31:0] e);
    rd(a);
    `CHK("reg", e, d)
  endtask
  task automatic op(input logic [31:0] c);
    int n = 0;
    wr(16'h0408, c);
    do begin
      rd(16'h0408);
      n++;
    end while (d[7] !== 1'b0 && n < 600);
    if (n >= 600) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic hr(input logic [47:0] k);
    wr(16'h0400, {16'h0, k[47:32]});
    wr(16'h0404, k[31:0]);
    op(32'h82);
  endtask
  task automatic sw(input logic [47:0] k, input logic [31:0] ix, input logic [31:0] c);
    wr(16'h0420, 32'h8000_0000);
    wr(16'h0424, 32'h12);
    wr(16'h0428, {16'h0, k[47:32]});
    wr(16'h042c, k[31:0]);
    wr(16'h0400, {16'h0, k[47:32]});
    wr(16'h0404, ix);
    op(c);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (1030) @(posedge clock);
    for (int p = 1; p < 8; p++) begin
      ck({p[3:0], 12'hb01}, 32'h0);
      ck({p[3:0], 12'hb04}, 32'h6);
    end
    `CHK("ports", {56{1'b1}}, port_tx_en & port_rx_en & ~port_learn_dis)
    wr(16'h3b01, 32'hfd);
    wr(16'h3b04, 32'hf9);
    ck(16'h3b04, 32'h1);
    ck(16'h3b01, 32'hfd);
    `CHK("inst", 4'h3, {port_tx_en[21], port_rx_en[21], port_learn_dis[21], port_tx_en[20]})
    wr(16'h3b01, 32'h0);
    ck(16'h3b04, 32'h6);
    ck(16'h8b01, 32'h0);
    u_fwd.learn(48'ha0a, 3'h0, 3'h0);
    u_fwd.learn(48'hb0b, 3'h2, 3'h5);
    hr(48'ha0a);
    `CHK("found", 1'b1, d[6])
    ck(16'h0420, 32'h0c00_0000);
    ck(16'h042c, 32'ha0a);
    // with the group id in the hash and the compare, group 1 must miss the group 0 entry
    hash_fid_en <= 1'b1;
    wr(16'h0400, 32'h0001_0000);
    op(32'h82);
    `CHK("fid", 1'b0, d[6])
    hash_fid_en <= 1'b0;
    hr(48'hb0b);
    `CHK("found", 1'b0, d[6])
    ck(16'h0420, 32'h0);
    ck(16'h042c, 32'h0);
    u_fwd.lookup(48'ha0a);
    `CHK("da", 2'b10, {da_hit, da_static})
    sw(48'hc0c, 32'hc0c, 32'h81);
    `CHK("found", 1'b1, d[6])
    u_fwd.lookup(48'hc0c);
    `CHK("da", 9'h192, {da_hit, da_static, da_fwd})
    sw(48'hd0d_0d0d, 32'h5, 32'h85);
    op(32'h86);
    ck(16'h042c, 32'h0d0d_0d0d);
    wr(16'h0404, 32'h6);
    op(32'h86);
    `CHK("found", 1'b0, d[6])
    // these keys share bucket 2a under the xor fold hash
    for (int i = 1; i < 6; i++) begin
      m = {28'h0, i[9:0], i[9:0] ^ 10'h2a};
      sw(m, m[31:0], 32'h81);
      `CHK("found", i < 5, d[6])
      rd(16'h0418);
      `CHK("evt", {i == 5, i > 2 && i < 5}, d[1:0])
      rd(16'h0410);
      if (i > 2) `CHK("eidx0", 10'h2a, i < 5 ? d[11:2] : d[9:0])
      wr(16'h0418, 32'h7);
    end
    u_fwd.learn({28'h0, 10'h6, 10'h6 ^ 10'h2a}, 3'h0, 3'h0);
    ck(16'h0418, 32'h4);
    ck(16'h0414, 32'h2a);
    wr(16'h0408, 32'h83);
    wr(16'h0408, 32'h03);
    rd(16'h0408);
    `CHK("abort", 1'b0, d[7])
    cnt = 0;
    wr(16'h0408, 32'h83);
    d[7] = 1'b1;
    for (int n = 0; n < 2000 && d[7] === 1'b1; n++) begin
      rd(16'h0408);
      if (d[7] === 1'b1) `CHK("voe", d[6], d[5])
      if (d[7] === 1'b1 && d[6] === 1'b1) begin
        cnt++;
        for (int w = 0; w < 4; w++) rd(16'h0420 + 16'(4 * w));
        d[7] = 1'b1;
      end
    end
    `CHK("go", 1'b0, d[7])
    `CHK("count", 13'h7, d[28:16])
    `CHK("search", 7, cnt)
    ck(16'h0420, 32'h0);
    repeat (3) begin
      @(posedge clock);
      age_tick <= 1'b1;
      @(posedge clock);
      age_tick <= 1'b0;
      repeat (1100) @(posedge clock);
    end
    hr(48'ha0a);
    `CHK("aged", 1'b0, d[6])
    hr(48'hc0c);
    `CHK("static", 1'b1, d[6])
    end_of_test();
  end
endmodule
